// ### core/tcr_mem.sv
// Result word memory: one write port, one registered read port
`timescale 1ns/10ps
module tcr_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock
  input wire logic mclk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("tcr_mem: unsupported geometry");
  end

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // tcr_mem

// ### core/tcr_top.sv
// Four-channel millivolt input readout: sequencer, encoder, registers, interrupt
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "tcr_cfg.svh"
module tcr_top #(
  parameter int INTEG50_CYC = `TCR_INTEG50_CYC,
  parameter int INTEG60_CYC = `TCR_INTEG60_CYC,
  parameter int TEST_CYC = `TCR_TEST_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [`TCR_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Converter front end
  input wire logic [15:0] adc_units,
  input wire logic break_cmp,
  output logic [1:0] chan_sel,
  output logic integ,
  output logic test_pulse,
  // Indicators
  output logic fault_led,
  output logic irq
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (INTEG50_CYC < 1 || INTEG50_CYC >= (1 << `TCR_CNT_W) ||
      INTEG60_CYC < 1 || INTEG60_CYC >= (1 << `TCR_CNT_W) ||
      TEST_CYC < 1 || TEST_CYC >= (1 << `TCR_CNT_W)) begin : g_chk
    $error("tcr_top: count parameter out of range");
  end

  localparam logic [`TCR_CNT_W-1:0] P50 = `TCR_CNT_W'(INTEG50_CYC - 1);
  localparam logic [`TCR_CNT_W-1:0] P60 = `TCR_CNT_W'(INTEG60_CYC - 1);
  localparam logic [`TCR_CNT_W-1:0] PTEST = `TCR_CNT_W'(TEST_CYC - 1);

  tcr_pkg::tcr_state_s q, d;
  tcr_pkg::tcr_bus_s bus;
  logic signed [15:0] raw;
  logic [15:0] word;
  logic [1:0] cls_now;
  logic is_ovf;
  logic mem_we;
  logic [1:0] mem_raddr;
  logic [15:0] mem_rdata;
  logic [3:0] led_term;
  logic [5:0] sts_set;
  logic [5:0] sts_clr;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ----------------------------------------------------------------
  // Result encoding
  // ----------------------------------------------------------------
  assign raw = $signed(q.adc_s2);

  always_comb begin
    word = {raw[12:0], 3'b000};
    cls_now = tcr_pkg::TCR_NOMINAL;
    is_ovf = 1'b0;
    if (raw > `TCR_UNITS_MAX) begin
      word = `TCR_WORD_POS_OVF;
      cls_now = tcr_pkg::TCR_OVERFLOW;
      is_ovf = 1'b1;
    end else if (raw < -`TCR_UNITS_MAX) begin
      word = `TCR_WORD_NEG_OVF;
      cls_now = tcr_pkg::TCR_OVERFLOW;
      is_ovf = 1'b1;
    end else if (raw > `TCR_UNITS_RATED || raw < -`TCR_UNITS_RATED) begin
      cls_now = tcr_pkg::TCR_OVERRANGE;
    end
    word[`TCR_WORD_WB_BIT] = q.wb_seen & q.ctrl.wb_en;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    sts_set = 6'h00;
    sts_clr = 6'h00;
    d.adc_s1 = adc_units;
    d.adc_s2 = q.adc_s1;
    d.cmp_s1 = break_cmp;
    d.cmp_s2 = q.cmp_s1;
    case (q.st)
      tcr_pkg::TCR_IDLE: begin
        d.st = tcr_pkg::TCR_TEST;
        d.ch = 2'b00;
        d.cnt = PTEST;
        d.wb_seen = 1'b0;
      end
      tcr_pkg::TCR_TEST: begin
        if (q.cmp_s2) begin
          d.wb_seen = 1'b1;
        end
        if (q.cnt == '0) begin
          d.st = tcr_pkg::TCR_INTEG;
          d.per60 = q.ctrl.mains60;
          d.cnt = q.ctrl.mains60 ? P60 : P50;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      tcr_pkg::TCR_INTEG: begin
        if (q.cnt == '0) begin
          d.st = tcr_pkg::TCR_STORE;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      tcr_pkg::TCR_STORE: begin
        d.cls[q.ch*2 +: 2] = cls_now;
        d.wbf[q.ch] = q.wb_seen & q.ctrl.wb_en;
        sts_set[q.ch] = 1'b1;
        sts_set[`TCR_STS_WB_BIT] = q.wb_seen & q.ctrl.wb_en;
        sts_set[`TCR_STS_OVF_BIT] = is_ovf;
        // wrap after the last active channel
        d.ch = (q.ch >= q.ctrl.nch) ? 2'b00 : q.ch + 2'b01;
        d.st = tcr_pkg::TCR_TEST;
        d.cnt = PTEST;
        d.wb_seen = 1'b0;
      end
      default: begin
        d.st = tcr_pkg::TCR_IDLE;
      end
    endcase

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `TCR_OFS_CTRL: begin
          d.ctrl.mains60 = bus.wdata[`TCR_CTRL_MAINS60_BIT];
          d.ctrl.nch = bus.wdata[`TCR_CTRL_NCH_LSB +: 2];
          d.ctrl.wb_en = bus.wdata[`TCR_CTRL_WBEN_BIT];
        end
        `TCR_OFS_STATUS: sts_clr = bus.wdata[5:0];
        `TCR_OFS_MASK: d.mask = bus.wdata[5:0];
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    d.sts = (q.sts & ~sts_clr) | sts_set;

    // Register reads
    d.rd_mem = 1'b0;
    d.rdata = 32'h0;
    if (bus.rd) begin
      if (bus.addr[7:4] == `TCR_OFS_WORD_BASE && bus.addr[1:0] == 2'b00) begin
        d.rd_mem = 1'b1;
      end else begin
        case (bus.addr)
          `TCR_OFS_CTRL: d.rdata = {28'h0, q.ctrl.wb_en, q.ctrl.nch, q.ctrl.mains60};
          `TCR_OFS_STATUS: d.rdata = {26'h0, q.sts};
          `TCR_OFS_MASK: d.rdata = {26'h0, q.mask};
          `TCR_OFS_CLASS: d.rdata = {20'h0, q.wbf, q.cls};
          default: d.rdata = 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: tcr_pkg::TCR_IDLE, ch: 2'b00, cnt: '0, per60: 1'b0, wb_seen: 1'b0,
             ctrl: `TCR_CTRL_RESET, sts: `TCR_STS_RESET, mask: `TCR_MASK_RESET,
             cls: 8'h00, wbf: 4'h0, rdata: 32'h0, rd_mem: 1'b0, adc_s1: 16'h0,
             adc_s2: 16'h0, cmp_s1: 1'b0, cmp_s2: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Result memory
  // ----------------------------------------------------------------
  assign mem_we = (q.st == tcr_pkg::TCR_STORE);
  assign mem_raddr = bus.addr[3:2];

  tcr_mem #(
    .WIDTH(16),
    .DEPTH(4)
  ) u_mem (
    .mclk(mclk),
    .ce(ce),
    .we(mem_we),
    .waddr(q.ch),
    .wdata(word),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_led
    assign led_term[i] = q.wbf[i] & (2'(i) <= q.ctrl.nch);
  end

  assign rdata = q.rd_mem ? {16'h0, mem_rdata} : q.rdata;
  assign chan_sel = q.ch;
  assign integ = (q.st == tcr_pkg::TCR_INTEG);
  assign test_pulse = (q.st == tcr_pkg::TCR_TEST);
  assign fault_led = q.ctrl.wb_en & (|led_term);
  assign irq = |(q.sts & q.mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [`TCR_CNT_W-1:0] int_len;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_len <= '0;
    end else if (ce) begin
      int_len <= integ ? int_len + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  integ_length_a: assert property ($fell(integ) |->
    int_len == (q.per60 ? P60 + 1'b1 : P50 + 1'b1)) else $error("integration length wrong");
  chan_limit_a: assert property (q.st == tcr_pkg::TCR_STORE && ce && q.ch >= q.ctrl.nch
    |=> q.ch == 2'b00) else $error("channel did not wrap");
  break_flag_a: assert property (mem_we && q.wb_seen && q.ctrl.wb_en |->
    word[`TCR_WORD_WB_BIT]) else $error("break flag missing");
  led_gate_a: assert property (fault_led |-> q.ctrl.wb_en)
    else $error("indicator lit while disabled");
  break_detect_a: assert property (q.st == tcr_pkg::TCR_TEST && q.cmp_s2 && ce && q.cnt != '0
    |=> q.wb_seen) else $error("break not caught");
  pulse_always_a: assert property (q.st == tcr_pkg::TCR_TEST |-> test_pulse)
    else $error("test current off");
  word_value_a: assert property (mem_we && !is_ovf |->
    word[15:3] == raw[12:0] && word[0] == 1'b0) else $error("word layout wrong");
  ovf_code_a: assert property (mem_we && raw > `TCR_UNITS_MAX |->
    word == (`TCR_WORD_POS_OVF | {14'h0, word[1], 1'b0})) else $error("overflow code wrong");
  hold_word_a: assert property (mem_we |-> q.st == tcr_pkg::TCR_STORE ##1 !mem_we)
    else $error("word replaced outside completion");

  ovf_seen_c: cover property (mem_we && is_ovf);
  break_seen_c: cover property (mem_we && word[`TCR_WORD_WB_BIT]);
  four_chan_c: cover property (mem_we && q.ch == 2'b11);
endmodule // tcr_top

// ### inc/tcr_cfg.svh
// Constants of the thermocouple input readout: offsets, fields, resets, timing
//
// Overview of operation
// - Mains setting picks 20 ms or 16.66 ms
// - Convert only channels zero up to count
// - Enabled break lights LED, sets flag bit
// - Test current; over-limit voltage means break
// - Test pulses continue while signalling is off
// - Left-justified word, value in bits 15:3
// - Nominal, overrange, overflow classes; bit0 set on overflow only
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TCR_CLK_NS 5
`define TCR_T_INTEG50_US 20000
`define TCR_T_INTEG60_US 16660
`define TCR_T_TEST_US 100
`define TCR_INTEG50_CYC (`TCR_T_INTEG50_US * 1000 / `TCR_CLK_NS)
`define TCR_INTEG60_CYC (`TCR_T_INTEG60_US * 1000 / `TCR_CLK_NS)
`define TCR_TEST_CYC (`TCR_T_TEST_US * 1000 / `TCR_CLK_NS)
`define TCR_CNT_W 23

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define TCR_ADDR_W 8
`define TCR_OFS_CTRL 8'h00
`define TCR_OFS_STATUS 8'h04
`define TCR_OFS_MASK 8'h08
`define TCR_OFS_CLASS 8'h0c
`define TCR_OFS_WORD_BASE 4'h1

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define TCR_CTRL_MAINS60_BIT 0
`define TCR_CTRL_NCH_LSB 1
`define TCR_CTRL_WBEN_BIT 3
`define TCR_CTRL_RESET 4'h0
`define TCR_STS_WB_BIT 4
`define TCR_STS_OVF_BIT 5
`define TCR_STS_RESET 6'h00
`define TCR_MASK_RESET 6'h00
`define TCR_WORD_LSB 3
`define TCR_WORD_WB_BIT 1
`define TCR_WORD_OVF_BIT 0
`define TCR_UNITS_MAX 16'sh0fff
`define TCR_UNITS_RATED 16'sh0800
`define TCR_WORD_POS_OVF 16'h7ff9
`define TCR_WORD_NEG_OVF 16'h8009

`endif

// ### inc/tcr_pkg.sv
// Types of the thermocouple input readout
`include "tcr_cfg.svh"
package tcr_pkg;
  typedef enum logic [1:0] {
    TCR_IDLE = 2'b00,
    TCR_TEST = 2'b01,
    TCR_INTEG = 2'b10,
    TCR_STORE = 2'b11
  } tcr_state_e;

  typedef enum logic [1:0] {
    TCR_NOMINAL = 2'b00,
    TCR_OVERRANGE = 2'b01,
    TCR_OVERFLOW = 2'b10
  } tcr_class_e;

  typedef struct packed {
    logic [`TCR_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tcr_bus_s;

  typedef struct packed {
    logic wb_en;
    logic [1:0] nch;
    logic mains60;
  } tcr_ctrl_s;

  typedef struct packed {
    tcr_state_e st;
    logic [1:0] ch;
    logic [`TCR_CNT_W-1:0] cnt;
    logic per60;
    logic wb_seen;
    tcr_ctrl_s ctrl;
    logic [5:0] sts;
    logic [5:0] mask;
    logic [7:0] cls;
    logic [3:0] wbf;
    logic [31:0] rdata;
    logic rd_mem;
    logic [15:0] adc_s1;
    logic [15:0] adc_s2;
    logic cmp_s1;
    logic cmp_s2;
  } tcr_state_s;
endpackage

// ### verification/tcr_front_model.sv
// Analog front end model: per-channel converter result and break comparator
`timescale 1ns/10ps
module tcr_front_model (
  // Channel selection from the readout
  input wire logic [1:0] chan_sel,
  input wire logic test_pulse,
  // Scene set by the bench
  input wire logic [3:0][15:0] ch_units,
  input wire logic [3:0] ch_open,
  // Converter outputs
  output logic [15:0] adc_units,
  output logic break_cmp
);
  // voltage over limit
  // An open input exceeds the limit only while the test current flows
  assign break_cmp = test_pulse & ch_open[chan_sel];
  assign adc_units = ch_units[chan_sel];
endmodule // tcr_front_model

// ### verification/tcr_top_tb.sv
// Self-checking bench of the four-channel millivolt readout
`timescale 1ns/10ps
module tcr_top_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0][15:0] units = '0;
  logic [3:0] opn = 4'h0;
  logic [15:0] adc_units;
  logic break_cmp;
  logic integ;
  logic test_pulse;
  logic tp_q = 1'b0;
  logic fault_led;
  logic irq;
  logic [1:0] chan_sel;
  int fails = 0;
  int checks_done = 0;
  int ilen = 0;
  int run = 0;
  int pulses = 0;

  always #2.5 mclk = ~mclk;

  tcr_top #(.INTEG50_CYC(20), .INTEG60_CYC(17), .TEST_CYC(4)) tcr_top_inst (
    .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .adc_units(adc_units), .break_cmp(break_cmp), .chan_sel(chan_sel),
    .integ(integ), .test_pulse(test_pulse), .fault_led(fault_led), .irq(irq));

  tcr_front_model tcr_front_model_inst (
    .chan_sel(chan_sel), .test_pulse(test_pulse), .ch_units(units), .ch_open(opn),
    .adc_units(adc_units), .break_cmp(break_cmp));

  // Length of the last integration and count of test pulses
  always @(posedge mclk) begin
    run <= integ ? run + 1 : 0;
    if (!integ && run != 0) ilen <= run;
    if (test_pulse && !tp_q) pulses <= pulses + 1;
    tp_q <= test_pulse;
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rreg(logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Poll the done bits under a bound
  task automatic wait_done(logic [3:0] m);
    for (int i = 0; i < 200; i++) begin
      rreg(8'h04, rv);
      if ((rv[3:0] & m) == m) return;
    end
    fails++;
    test_done();
  endtask

  function automatic logic [15:0] exp_word(logic signed [15:0] u, logic b);
    logic [15:0] w;
    w = (u > 4095) ? 16'h7ff9 : (u < -4095) ? 16'h8009 : 16'(u <<< 3);
    return w | {14'h0, b, 1'b0};
  endfunction

  function automatic logic [1:0] exp_cls(logic signed [15:0] u);
    int a;
    a = int'(u);
    if (a < 0) a = -a;
    return (a <= 2048) ? 2'h0 : (a <= 4095) ? 2'h1 : 2'h2;
  endfunction

  initial begin
    int p0;
    logic [3:0] ctl;
    logic [7:0] ec;
    void'($urandom(36));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rreg(8'(i * 4), rv);
      chk("reset reg", 32'h0, rv);
    end
    wreg(8'h24, 32'hff);
    rreg(8'h24, rv);
    chk("unmapped", 32'h0, rv);
    // ----------------------------------------------------------------
    // Boundary and random values, both mains settings
    // ----------------------------------------------------------------
    for (int r = 0; r < 2; r++) begin
      if (r == 0) begin
        units <= {16'hec78, 16'h1388, 16'h0801, 16'($urandom_range(8190) - 4095)};
      end else begin
        units <= {16'h1000, 16'hf001, 16'hf7ff, 16'h0800};
      end
      opn <= r ? 4'h1 : 4'h8;
      ctl = r ? 4'h7 : 4'he;
      wreg(8'h00, {28'h0, ctl});
      rreg(8'h00, rv);
      chk("ctrl", {28'h0, ctl}, rv);
      repeat (2) begin
        p0 = pulses;
        wreg(8'h04, 32'h3f);
        wait_done(4'hf);
      end
      chk("irq masked", 32'h0, {31'h0, irq});
      chk("integ cycles", ctl[0] ? 32'h11 : 32'h14, ilen);
      chk("test pulses", 32'h1, {31'h0, pulses - p0 >= 4});
      for (int c = 0; c < 4; c++) begin
        rreg(8'(8'h10 + 4 * c), rv);
        chk("word", {16'h0, exp_word(units[c], ctl[3] & opn[c])}, rv);
        ec[2*c +: 2] = exp_cls(units[c]);
      end
      rreg(8'h0c, rv);
      chk("class", {24'h0, ec}, {24'h0, rv[7:0]});
      chk("fault led", {31'h0, ctl[3] & |opn}, {31'h0, fault_led});
    end
    // ----------------------------------------------------------------
    // One channel, interrupt raise and clear, held words
    // ----------------------------------------------------------------
    wreg(8'h00, 32'h0);
    wreg(8'h08, 32'h1);
    rreg(8'h08, rv);
    chk("mask", 32'h1, rv);
    wreg(8'h04, 32'h3f);
    wait_done(4'h1);
    wreg(8'h04, 32'h3f);
    wait_done(4'h1);
    chk("status", 32'h1, rv);
    chk("chan sel", 32'h0, {30'h0, chan_sel});
    chk("irq", 32'h1, {31'h0, irq});
    wreg(8'h04, 32'h1);
    #1 chk("irq clear", 32'h0, {31'h0, irq});
    rreg(8'h14, rv);
    chk("held word", {16'h0, exp_word(16'hf7ff, 1'b0)}, rv);
    test_done();
  end
endmodule // tcr_top_tb
